// ---- hw/dpc_map.svh ----
// register map, field positions and codes of the digital path control
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

`define DPC_ADC_W 14

// register indices; byte address is four times the index
`define DPC_IDX_ROUTE 10'h024
`define DPC_IDX_DECIM 10'h025
`define DPC_IDX_STATUS 10'h030
`define DPC_ADDR_ROUTE ({`DPC_IDX_ROUTE, 2'b00})
`define DPC_ADDR_DECIM ({`DPC_IDX_DECIM, 2'b00})
`define DPC_ADDR_STATUS ({`DPC_IDX_STATUS, 2'b00})

`define DPC_ROUTE_RESET 8'h00
`define DPC_DECIM_RESET 8'h00

// path_routing_control fields
`define DPC_AVG_BIT 5
`define DPC_SEL_HI 4
`define DPC_SEL_LO 3
`define DPC_FEAT_BIT 2
`define DPC_DEC_EN_BIT 1

// decimation_mode_control fields
`define DPC_SEL_EN_BIT 7
`define DPC_FACT_HI 6
`define DPC_FACT_LO 4
`define DPC_REAL_BIT 3
`define DPC_PHASE_BIT 0

// status word fields
`define DPC_ST_FEAT_BIT 0
`define DPC_ST_DON_BIT 1
`define DPC_ST_LG_HI 4
`define DPC_ST_LG_LO 2
`define DPC_ST_REAL_BIT 5
`define DPC_ST_MIX_BIT 6
`define DPC_ST_INV_BIT 7
`define DPC_ST_AVG_BIT 8
`define DPC_ST_SEL_BIT 9

// selector and factor codes
`define DPC_SEL_STRAIGHT 2'h0
`define DPC_SEL_ALL_A 2'h1
`define DPC_SEL_ALL_B 2'h2
`define DPC_SEL_AVG 2'h3
`define DPC_FACT_BYPASS 3'h0
`define DPC_FACT_MAX 3'h5

`endif

// ---- hw/dpc_pkg.sv ----
// types shared by the digital path control modules
package dpc_pkg;

  typedef enum logic [1:0] {
    route_straight,
    route_all_a,
    route_all_b,
    route_average
  } dpc_route_e;

  typedef enum logic {
    apb_idle,
    apb_answer
  } dpc_apb_e;

  typedef struct packed {
    logic [13:0] a;
    logic [13:0] b;
    logic v;
  } dpc_route_s;

  typedef struct packed {
    logic [7:0] route_reg;
    logic [7:0] decim_reg;
    dpc_apb_e apb;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [4:0] dcnt;
    logic [13:0] oa;
    logic [13:0] ob;
    logic ov;
    logic feat;
    logic don;
    logic [2:0] lg;
    logic rmode;
    logic mix;
    logic inv;
    logic avg;
    logic sel_on;
  } dpc_state_s;

endpackage : dpc_pkg

// ---- hw/dpc_route.sv ----
// input selector and channel averaging stage ahead of the two paths
`timescale 1ns/1ns
`default_nettype none
`include "dpc_map.svh"

module dpc_route (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [13:0] in_a,
  input wire logic [13:0] in_b,
  input wire logic in_valid,
  input wire dpc_pkg::dpc_route_e route,
  output logic [13:0] out_a,
  output logic [13:0] out_b,
  output logic out_valid
);

  dpc_pkg::dpc_route_s s;
  dpc_pkg::dpc_route_s next_s;
  logic [14:0] sum;
  logic [13:0] mean;
  logic [13:0] pick [2];

  ////////////////////////////////////////////////////////////////
  // samples are two's complement, so the halving keeps the sign
  // [R1] average of channels
  assign sum = {in_a[13], in_a} + {in_b[13], in_b};
  assign mean = sum[14:1];

  // path 0 is path A, path 1 is path B
  for (genvar g = 0; g < 2; g++) begin : g_path
    always_comb begin
      case (route)
        // [R3] fixed channel routes
        dpc_pkg::route_all_a: pick[g] = in_a;
        dpc_pkg::route_all_b: pick[g] = in_b;
        // [R4] averaged sample to both
        dpc_pkg::route_average: pick[g] = mean;
        default: pick[g] = (g == 0) ? in_a : in_b;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.v = in_valid;
    if (in_valid) begin
      next_s.a = pick[0];
      next_s.b = pick[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_a = s.a;
  assign out_b = s.b;
  assign out_valid = s.v;

endmodule : dpc_route
`default_nettype wire

// ---- hw/dpc_path_ctrl.sv ----
// register file and path control of the dual converter feature path
//
// Function
// [R1] With averaging on, the sample fed onward is (A+B)/2, otherwise none.
// [R2] Software enables the selector at code 11, the decimator and the path.
// [R3] Selector code 00 is straight, 01 sends A to both, 10 sends B to both.
// [R4] Selector code 11 sends the averaged sample to both paths.
// [R5] Path bit 0 bypasses all features; 1 sends data through them. In bypass, nco_phase_invert still follows the phase bit.
// [R6] The decimator enable bit turns decimation on for both channels.
// [R7] The selector code only acts while the selector enable bit is 1.
// [R8] Factor 000 is no decimation, 001 to 101 give 2 to 32, rest unused.
// [R9] Real output bit 1 gives low-pass real decimation without mixing.
// [R10] Software should zero the oscillator frequency in real mode.
// [R11] Phase invert bit 1 inverts the oscillator phase, 0 leaves it.
`timescale 1ns/1ns
`default_nettype none
`include "dpc_map.svh"

module dpc_path_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [13:0] adc_a,
  input wire logic [13:0] adc_b,
  input wire logic adc_valid,
  output logic [13:0] path_a_data,
  output logic [13:0] path_b_data,
  output logic path_valid,
  output logic feature_path_active,
  output logic decimator_active,
  output logic [2:0] decim_log2,
  output logic real_decimation,
  output logic mixer_enable,
  output logic nco_phase_invert,
  output logic channel_average_active
);

  dpc_pkg::dpc_state_s s;
  dpc_pkg::dpc_state_s next_s;
  dpc_pkg::dpc_route_e route_now;
  logic [13:0] mux_a;
  logic [13:0] mux_b;
  logic mux_v;
  logic [2:0] lg_now;
  logic [4:0] limit;
  logic setup;
  logic access;
  logic hit_route;
  logic hit_decim;
  logic hit_status;

  ////////////////////////////////////////////////////////////////
  // decoding used by the data path and by the status read

  function automatic dpc_pkg::dpc_route_e eff_route(
    input logic [7:0] r,
    input logic [7:0] d
  );
    logic [1:0] code;
    code = r[`DPC_SEL_HI:`DPC_SEL_LO];
    eff_route = dpc_pkg::route_straight;
    // [R5] bypass skips the selector
    if (!r[`DPC_FEAT_BIT]) begin
      eff_route = dpc_pkg::route_straight;
    // [R7] selector gated by enable
    end else if (!d[`DPC_SEL_EN_BIT]) begin
      eff_route = dpc_pkg::route_straight;
    end else begin
      case (code)
        // [R3] selector codes
        `DPC_SEL_ALL_A: eff_route = dpc_pkg::route_all_a;
        `DPC_SEL_ALL_B: eff_route = dpc_pkg::route_all_b;
        `DPC_SEL_AVG: begin
          // [R1] averaging needs enable bit
          if (r[`DPC_AVG_BIT]) begin
            // [R4] average to both paths
            eff_route = dpc_pkg::route_average;
          end else begin
            eff_route = dpc_pkg::route_straight;
          end
        end
        default: eff_route = dpc_pkg::route_straight;
      endcase
    end
  endfunction : eff_route

  function automatic logic [2:0] eff_log2(
    input logic [7:0] r,
    input logic [7:0] d
  );
    logic [2:0] f;
    f = d[`DPC_FACT_HI:`DPC_FACT_LO];
    eff_log2 = `DPC_FACT_BYPASS;
    // [R5] no decimation in bypass
    if (!r[`DPC_FEAT_BIT]) begin
      eff_log2 = `DPC_FACT_BYPASS;
    // [R6] decimator off for both
    end else if (!r[`DPC_DEC_EN_BIT]) begin
      eff_log2 = `DPC_FACT_BYPASS;
    // [R8] unused codes act as bypass
    end else if (f > `DPC_FACT_MAX) begin
      eff_log2 = `DPC_FACT_BYPASS;
    end else begin
      eff_log2 = f;
    end
  endfunction : eff_log2

  // status word, one bit per flag and a three-bit factor field
  function automatic logic [31:0] status_word(
    input dpc_pkg::dpc_state_s st
  );
    status_word = 32'h0000_0000;
    status_word[`DPC_ST_FEAT_BIT] = st.feat;
    status_word[`DPC_ST_DON_BIT] = st.don;
    status_word[`DPC_ST_LG_HI:`DPC_ST_LG_LO] = st.lg;
    status_word[`DPC_ST_REAL_BIT] = st.rmode;
    status_word[`DPC_ST_MIX_BIT] = st.mix;
    status_word[`DPC_ST_INV_BIT] = st.inv;
    status_word[`DPC_ST_AVG_BIT] = st.avg;
    status_word[`DPC_ST_SEL_BIT] = st.sel_on;
  endfunction : status_word

  // unmapped offsets and writes to the read-only status word fail
  function automatic logic bus_fault(
    input logic w,
    input logic [11:0] a
  );
    bus_fault = 1'b1;
    if (a == `DPC_ADDR_ROUTE || a == `DPC_ADDR_DECIM) begin
      bus_fault = 1'b0;
    end else if (a == `DPC_ADDR_STATUS) begin
      bus_fault = w;
    end
  endfunction : bus_fault

  assign route_now = eff_route(s.route_reg, s.decim_reg);
  assign lg_now = eff_log2(s.route_reg, s.decim_reg);

  ////////////////////////////////////////////////////////////////
  // selector and averaging stage, one cycle of latency

  dpc_route u_route (
    .pclk(pclk),
    .presetn(presetn),
    .in_a(adc_a),
    .in_b(adc_b),
    .in_valid(adc_valid),
    .route(route_now),
    .out_a(mux_a),
    .out_b(mux_b),
    .out_valid(mux_v)
  );

  ////////////////////////////////////////////////////////////////
  // bus decode

  assign setup = psel && !penable;
  assign access = psel && penable && s.ready;
  assign hit_route = (paddr == `DPC_ADDR_ROUTE);
  assign hit_decim = (paddr == `DPC_ADDR_DECIM);
  assign hit_status = (paddr == `DPC_ADDR_STATUS);

  // samples dropped per output: one less than two to the factor
  assign limit = 5'((6'h01 << s.lg) - 6'h01);

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;

    // answer is prepared in setup so the access phase needs no wait
    case (s.apb)
      dpc_pkg::apb_idle: begin
        next_s.ready = 1'b0;
        next_s.err = 1'b0;
        if (setup) begin
          next_s.apb = dpc_pkg::apb_answer;
          next_s.ready = 1'b1;
          // error flag only ever rises together with ready
          next_s.err = bus_fault(pwrite, paddr);
          next_s.rdata = 32'h0000_0000;
          if (!pwrite) begin
            if (hit_route) begin
              next_s.rdata = {24'h00_0000, s.route_reg};
            end else if (hit_decim) begin
              next_s.rdata = {24'h00_0000, s.decim_reg};
            end else if (hit_status) begin
              next_s.rdata = status_word(s);
            end
          end
        end
      end
      dpc_pkg::apb_answer: begin
        if (access) begin
          next_s.apb = dpc_pkg::apb_idle;
          next_s.ready = 1'b0;
          next_s.err = 1'b0;
          // all eight bits stored as written, reserved ones too
          if (pwrite && hit_route) begin
            next_s.route_reg = pwdata[7:0];
          end
          if (pwrite && hit_decim) begin
            next_s.decim_reg = pwdata[7:0];
          end
        end else if (!psel) begin
          // master abandoned the transfer; drop the answer
          next_s.apb = dpc_pkg::apb_idle;
          next_s.ready = 1'b0;
          next_s.err = 1'b0;
        end
      end
      default: begin
        next_s.apb = dpc_pkg::apb_idle;
        next_s.ready = 1'b0;
        next_s.err = 1'b0;
      end
    endcase

    // control outputs follow the registers one cycle later
    // [R5] feature path select
    next_s.feat = s.route_reg[`DPC_FEAT_BIT];
    // [R6] decimator on only with the path active
    next_s.don = s.route_reg[`DPC_FEAT_BIT]
      && s.route_reg[`DPC_DEC_EN_BIT];
    // [R8] factor as power of two
    next_s.lg = lg_now;
    // [R9] real mode drops the mixer
    next_s.rmode = next_s.don && s.decim_reg[`DPC_REAL_BIT];
    next_s.mix = next_s.don && !s.decim_reg[`DPC_REAL_BIT];
    // [R11] oscillator phase invert
    next_s.inv = s.decim_reg[`DPC_PHASE_BIT];
    // [R1] averaging reported only when in use
    next_s.avg = (route_now == dpc_pkg::route_average);
    // [R7] selector enable in effect
    next_s.sel_on = s.route_reg[`DPC_FEAT_BIT]
      && s.decim_reg[`DPC_SEL_EN_BIT];

    // the filter taps sit downstream; this stage only paces the
    // stream so a factor change restarts the phase count
    next_s.ov = 1'b0;
    if (s.lg != lg_now) begin
      next_s.dcnt = 5'h00;
    end else if (mux_v) begin
      if (s.dcnt >= limit) begin
        // [R8] one output per 2^n samples
        next_s.dcnt = 5'h00;
        next_s.ov = 1'b1;
        next_s.oa = mux_a;
        next_s.ob = mux_b;
      end else begin
        next_s.dcnt = 5'(s.dcnt + 5'h01);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.route_reg <= `DPC_ROUTE_RESET;
      s.decim_reg <= `DPC_DECIM_RESET;
      s.apb <= dpc_pkg::apb_idle;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////
  // every output straight from the state register

  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.err;
  assign path_a_data = s.oa;
  assign path_b_data = s.ob;
  assign path_valid = s.ov;
  assign feature_path_active = s.feat;
  assign decimator_active = s.don;
  assign decim_log2 = s.lg;
  assign real_decimation = s.rmode;
  assign mixer_enable = s.mix;
  assign nco_phase_invert = s.inv;
  assign channel_average_active = s.avg;

endmodule : dpc_path_ctrl
`default_nettype wire

// ---- dv/dpc_path_ctrl_props.sv ----
// port checker of the digital path control
`timescale 1ns/1ns
`default_nettype none
`include "dpc_map.svh"

module dpc_path_ctrl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_valid,
  input wire logic path_valid,
  input wire logic feature_path_active,
  input wire logic decimator_active,
  input wire logic [2:0] decim_log2,
  input wire logic real_decimation,
  input wire logic mixer_enable,
  input wire logic nco_phase_invert
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_route;
  logic wr_decim;
  assign wr_route = psel && penable && pready && pwrite &&
    paddr == `DPC_ADDR_ROUTE;
  assign wr_decim = psel && penable && pready && pwrite &&
    paddr == `DPC_ADDR_DECIM;
  ////////////////////////////////////////
  // flags lag the register write by one cycle
  feat_follow_a: assert property (wr_route |=> ##1
    feature_path_active == $past(pwdata[2], 2)) else $error("path flag");
  dec_follow_a: assert property (wr_route |=> ##1
    decimator_active == ($past(pwdata[2], 2) && $past(pwdata[1], 2)))
    else $error("decimator flag");
  phase_follow_a: assert property (wr_decim |=> ##1
    nco_phase_invert == $past(pwdata[0], 2)) else $error("phase flag");
  real_mode_a: assert property (wr_decim |=> ##1
    real_decimation == (decimator_active && $past(pwdata[3], 2)))
    else $error("real flag");
  mixer_excl_a: assert property (mixer_enable |->
    decimator_active && !real_decimation) else $error("mixer flag");
  factor_range_a: assert property (decim_log2 != 3'h0 |->
    decimator_active && decim_log2 <= 3'h5) else $error("factor");
  // factor must stay at zero through the cycle the sample is paced in
  full_rate_a: assert property (adc_valid && decim_log2 == 3'h0
    ##1 decim_log2 == 3'h0 ##1 decim_log2 == 3'h0 |-> path_valid)
    else $error("sample lost");
  valid_cause_a: assert property (path_valid |->
    $past(adc_valid, 2)) else $error("spurious sample");
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone err");
endmodule : dpc_path_ctrl_props

bind dpc_path_ctrl dpc_path_ctrl_props i_dpc_path_ctrl_props (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .adc_valid, .path_valid, .feature_path_active, .decimator_active,
  .decim_log2, .real_decimation, .mixer_enable, .nco_phase_invert);
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench of the digital path control
`timescale 1ns/1ns
`default_nettype none
`include "dpc_map.svh"

module testbench;
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] d;
    logic [13:0] ea;
    logic [13:0] eb;
    logic [11:0] st;
  } dpc_row_s;
  localparam logic [13:0] A = 14'h3FF0;
  localparam logic [13:0] B = 14'h0005;
  // (A+B)/2 rounds toward minus infinity
  localparam logic [13:0] M = 14'h3FFA;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, adc_valid, path_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] adc_a, adc_b, path_a_data, path_b_data;
  logic feature_path_active, decimator_active, real_decimation;
  logic mixer_enable, nco_phase_invert, channel_average_active, er, v;
  logic [2:0] decim_log2;
  logic [11:0] ad;
  logic [31:0] ex;
  logic [8:0] fl;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int cnt;
  dpc_row_s rows [10] = '{
    '{8'h00, 8'h00, A, B, 12'h000},
    '{8'h04, 8'h80, A, B, 12'h201},
    '{8'h0C, 8'h80, A, A, 12'h201},
    '{8'h14, 8'h80, B, B, 12'h201},
    // selector at 11, decimator and path on
    '{8'h3E, 8'h80, M, M, 12'h343},
    '{8'h1C, 8'h80, A, B, 12'h201},
    '{8'h0C, 8'h00, A, B, 12'h001},
    '{8'h08, 8'h80, A, B, 12'h000},
    '{8'h02, 8'h09, A, B, 12'h080},
    // real mode; no oscillator word to program here
    '{8'h06, 8'h08, A, B, 12'h023}
  };

  dpc_path_ctrl i_dpc_path_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .adc_a, .adc_b, .adc_valid,
    .path_a_data, .path_b_data, .path_valid, .feature_path_active,
    .decimator_active, .decim_log2, .real_decimation, .mixer_enable,
    .nco_phase_invert, .channel_average_active);

  initial forever #2 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one idle cycle after each transfer keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic smp(output logic ok);
    int n;
    n = 0;
    adc_valid <= 1'b1;
    @(posedge pclk);
    adc_valid <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (path_valid !== 1'b1 && n < 8);
    ok = path_valid;
  endtask : smp

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    {psel, penable, pwrite, adc_valid} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    adc_a = A;
    adc_b = B;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and read back
    for (int k = 0; k < 2; k++) begin
      ad = k ? `DPC_ADDR_DECIM : `DPC_ADDR_ROUTE;
      apb(1'b0, ad, 32'h0, rd, er);
      chk(rd, 32'h0);
      apb(1'b1, ad, 32'hFFFF_FFA5, rd, er);
      apb(1'b0, ad, 32'h0, rd, er);
      chk(rd, 32'h0000_00A5);
      chk({31'h0, er}, 32'h0);
    end
    apb(1'b1, `DPC_ADDR_STATUS, 32'h1, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h098, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("register test done");
    foreach (rows[i]) begin
      apb(1'b1, `DPC_ADDR_ROUTE, {24'h0, rows[i].r}, rd, er);
      apb(1'b1, `DPC_ADDR_DECIM, {24'h0, rows[i].d}, rd, er);
      apb(1'b0, `DPC_ADDR_STATUS, 32'h0, rd, er);
      chk(rd, {20'h0, rows[i].st});
      fl = {channel_average_active, nco_phase_invert, mixer_enable,
        real_decimation, decim_log2, decimator_active, feature_path_active};
      chk({23'h0, fl}, {23'h0, rows[i].st[8:0]});
      smp(v);
      ex = {4'h1, rows[i].ea, rows[i].eb};
      chk({3'h0, v, path_a_data, path_b_data}, ex);
    end
    $display("table test done");
    for (int f = 0; f < 8; f++) begin
      apb(1'b1, `DPC_ADDR_DECIM, {25'h0, f[2:0], 4'h0}, rd, er);
      apb(1'b0, `DPC_ADDR_STATUS, 32'h0, rd, er);
      chk(rd, 32'h43 | ((f <= 5 ? f : 0) << 2));
      chk({29'h0, decim_log2}, (f <= 5) ? f : 0);
      cnt = 0;
      adc_valid <= 1'b1;
      for (int i = 0; i < 68; i++) begin
        @(posedge pclk);
        if (i == 63) adc_valid <= 1'b0;
        if (path_valid === 1'b1) cnt++;
      end
      chk(cnt, 64 >> (f <= 5 ? f : 0));
    end
    $display("factor test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    fl = {channel_average_active, nco_phase_invert, mixer_enable,
      real_decimation, decim_log2, decimator_active, feature_path_active};
    chk({22'h0, fl, path_valid}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `DPC_ADDR_ROUTE, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b0, `DPC_ADDR_DECIM, 32'h0, rd, er);
    chk(rd, 32'h0);
    $display("reset test done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
